// >>> include/pgl_cfg.svh
`ifndef PGL_CFG_SVH
`define PGL_CFG_SVH
`define PGL_ADDR_W 8
`define PGL_OFF_RAIL_MASK 8'hAA
`define PGL_OFF_PIN_MASK 8'hAB
`define PGL_OFF_CTL_MASK 8'hAC
`define PGL_OFF_LINREG 8'hAE
`define PGL_OFF_STATUS 8'hAF
`define PGL_RST_RAIL_MASK 8'h40
`define PGL_RST_PIN_MASK 8'h8E
`define PGL_RST_CTL_MASK 8'hFF
`define PGL_RST_LINREG 8'h7D
`define PGL_B_LINREG2 7
`define PGL_B_IN5 7
`define PGL_B_IN4 6
`define PGL_B_IN2 5
`define PGL_B_IN1 4
`define PGL_B_TERM 3
`define PGL_B_LINREG3 0
`define PGL_B_O1_IN3 7
`define PGL_B_O1_IN6 6
`define PGL_B_O4_IN3 5
`define PGL_B_O4_IN6 4
`define PGL_B_O2_IN3 3
`define PGL_B_O2_IN6 2
`define PGL_B_O3_IN3 1
`define PGL_B_O3_IN6 0
`define PGL_B_SDWN_CFG 5
`define PGL_B_ENABLE 0
`define PGL_VID_MSB 4
`define PGL_VID_LSB 1
`define PGL_DIS_MSB 7
`define PGL_DIS_LSB 6
`define PGL_CLK_NS 100
`define PGL_ESD_MS 1
`define PGL_ESD_CYC (`PGL_ESD_MS * 1000000 / `PGL_CLK_NS)
`endif

// >>> include/pgl_pkg.sv
package pgl_pkg;
    typedef logic [7:0] pgl_byte_t;
    typedef enum logic [1:0] {PGL_DIS_NONE, PGL_DIS_100, PGL_DIS_200, PGL_DIS_500} pgl_dis_e;
    typedef enum {PGL_ST_RUN, PGL_ST_SHUT} pgl_esd_e;
endpackage : pgl_pkg

// >>> core/pgl_regbank.sv
// Functional notes
// [R1] out3 rail mask bit7 excludes linreg two
// [R2] out3 rail mask bits5..0 exclude stepdown rails
// [R3] out3 pin mask bits7..4 exclude inputs 5,4,2,1
// [R4] out3 pin mask bit3 excludes termination regulator
// [R5] out3 pin mask bit0 excludes linreg three
// [R6] shared mask bits7,6 gate inputs into out1
// [R7] shared mask bits5,4 gate inputs into out4
// [R8] shared mask bits3,2 gate inputs into out2
// [R9] shared mask bits1,0 gate inputs into out3
// [R10] discharge code selects none/100/200/500 ohm
// [R11] shutdown cfg zero: off during emergency
// [R12] shutdown cfg one: enable bit only
// [R13] four-bit voltage code drives regulator target
// [R14] reset loads factory programmed defaults
// [R15] power good high only in regulation
// [R16] tree good when all unmasked good
// [R17] reserved bits store but do nothing
//
// Implementation choice: the strobed register port.
`include "pgl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module pgl_regbank #(
    parameter logic [7:0] OTP_RAIL_MASK = `PGL_RST_RAIL_MASK,
    parameter logic [7:0] OTP_PIN_MASK = `PGL_RST_PIN_MASK,
    parameter logic [7:0] OTP_CTL_MASK = `PGL_RST_CTL_MASK,
    parameter logic [7:0] OTP_LINREG = `PGL_RST_LINREG,
    parameter int ESD_CYCLES = `PGL_ESD_CYC
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [5:0] stepdown_pgood_in,
    input wire logic linreg_a_second_pgood_in,
    input wire logic linreg_a_third_pgood_in,
    input wire logic ddr_termination_pgood_in,
    input wire logic [5:0] control_input_in,
    input wire logic emergency_shutdown_in,
    output logic pgood_output_one_ctl_out,
    output logic pgood_output_two_ctl_out,
    output logic pgood_output_four_ctl_out,
    output logic pgood_output_three_out,
    output logic first_linreg_on_out,
    output logic [3:0] first_linreg_voltage_code_out,
    output logic [1:0] first_linreg_discharge_sel_out
);
    pgl_pkg::pgl_byte_t rail_mask;
    pgl_pkg::pgl_byte_t pin_mask;
    pgl_pkg::pgl_byte_t ctl_mask;
    pgl_pkg::pgl_byte_t linreg;
    logic [9:0] pg_meta;
    logic [9:0] pg_sync;
    logic [5:0] ctl_meta;
    logic [5:0] ctl_sync;
    logic esd_meta;
    logic esd_sync;
    pgl_pkg::pgl_esd_e esd_state;
    logic [31:0] esd_cnt;
    logic next_pg3;

    // included source is good, or its mask bit drops it from the tree
    function automatic logic term(input logic good, input logic excl);
        term = good | excl;
    endfunction : term

    // pins and rail flags are asynchronous to this clock
    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            pg_meta <= '0;
            pg_sync <= '0;
            ctl_meta <= '0;
            ctl_sync <= '0;
            esd_meta <= 1'b0;
            esd_sync <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pg_meta <= {ddr_termination_pgood_in, linreg_a_third_pgood_in,
                        linreg_a_second_pgood_in, 1'b0, stepdown_pgood_in};
            pg_sync <= pg_meta;
            ctl_meta <= control_input_in;
            ctl_sync <= ctl_meta;
            esd_meta <= emergency_shutdown_in;
            esd_sync <= esd_meta;
        end
    end

    // [R14] factory defaults at reset
    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            // factory programmed values arrive as parameters, one per part
            rail_mask <= OTP_RAIL_MASK;
            pin_mask <= OTP_PIN_MASK;
            ctl_mask <= OTP_CTL_MASK;
            linreg <= OTP_LINREG;
        end
        else if (clk_en_in && wr_in)
        begin
            // [R17] all eight bits stored, reserved included
            case (addr_in)
                `PGL_OFF_RAIL_MASK: rail_mask <= wdata_in;
                `PGL_OFF_PIN_MASK: pin_mask <= wdata_in;
                `PGL_OFF_CTL_MASK: ctl_mask <= wdata_in;
                `PGL_OFF_LINREG: linreg <= wdata_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
            rdata_out <= 8'h00;
        else if (clk_en_in)
        begin
            if (!rd_in)
                rdata_out <= 8'h00;
            else
            begin
                case (addr_in)
                    `PGL_OFF_RAIL_MASK: rdata_out <= rail_mask;
                    `PGL_OFF_PIN_MASK: rdata_out <= pin_mask;
                    `PGL_OFF_CTL_MASK: rdata_out <= ctl_mask;
                    `PGL_OFF_LINREG: rdata_out <= linreg;
                    `PGL_OFF_STATUS: rdata_out <= {6'h00, esd_state == pgl_pkg::PGL_ST_SHUT,
                                                   pgood_output_three_out};
                    default: rdata_out <= 8'h00;
                endcase
            end
        end
    end

    always_comb
    begin
        next_pg3 = 1'b1;
        // [R1] linreg two in out3 tree
        next_pg3 &= term(pg_sync[7], rail_mask[`PGL_B_LINREG2]);
        // [R2] stepdown rails, bit6 unused
        for (int i = 0; i < 6; i++)
            next_pg3 &= term(pg_sync[i], rail_mask[i]);
        // [R3] control inputs 5,4,2,1
        next_pg3 &= term(ctl_sync[4], pin_mask[`PGL_B_IN5]);
        next_pg3 &= term(ctl_sync[3], pin_mask[`PGL_B_IN4]);
        next_pg3 &= term(ctl_sync[1], pin_mask[`PGL_B_IN2]);
        next_pg3 &= term(ctl_sync[0], pin_mask[`PGL_B_IN1]);
        // [R4] termination regulator
        next_pg3 &= term(pg_sync[9], pin_mask[`PGL_B_TERM]);
        // [R5] linreg three
        next_pg3 &= term(pg_sync[8], pin_mask[`PGL_B_LINREG3]);
        // [R9] inputs 3 and 6 into out3
        next_pg3 &= term(ctl_sync[2], ctl_mask[`PGL_B_O3_IN3]);
        next_pg3 &= term(ctl_sync[5], ctl_mask[`PGL_B_O3_IN6]);
    end

    // [R16] [R15] registered and-tree of synchronised good flags
    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            pgood_output_three_out <= 1'b0;
            pgood_output_one_ctl_out <= 1'b0;
            pgood_output_two_ctl_out <= 1'b0;
            pgood_output_four_ctl_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pgood_output_three_out <= next_pg3;
            // [R6] out1 contribution from inputs 3 and 6
            pgood_output_one_ctl_out <= term(ctl_sync[2], ctl_mask[`PGL_B_O1_IN3])
                                      & term(ctl_sync[5], ctl_mask[`PGL_B_O1_IN6]);
            // [R8] out2 contribution
            pgood_output_two_ctl_out <= term(ctl_sync[2], ctl_mask[`PGL_B_O2_IN3])
                                      & term(ctl_sync[5], ctl_mask[`PGL_B_O2_IN6]);
            // [R7] out4 contribution
            pgood_output_four_ctl_out <= term(ctl_sync[2], ctl_mask[`PGL_B_O4_IN3])
                                       & term(ctl_sync[5], ctl_mask[`PGL_B_O4_IN6]);
        end
    end

    // [R11] emergency hold-off timer; factory duration is the parameter
    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            esd_state <= pgl_pkg::PGL_ST_RUN;
            esd_cnt <= 32'h0;
        end
        else if (clk_en_in)
        begin
            case (esd_state)
                pgl_pkg::PGL_ST_RUN:
                    if (esd_sync)
                    begin
                        esd_state <= pgl_pkg::PGL_ST_SHUT;
                        esd_cnt <= 32'(ESD_CYCLES - 1);
                    end
                pgl_pkg::PGL_ST_SHUT:
                    if (esd_cnt != 32'h0)
                        esd_cnt <= esd_cnt - 32'h1;
                    else if (!esd_sync)
                        esd_state <= pgl_pkg::PGL_ST_RUN;
                default: esd_state <= pgl_pkg::PGL_ST_RUN;
            endcase
        end
    end

    // [R12] [R11] [R13] [R10] regulator controls from the register
    always_ff @(posedge core_clk_in)
    begin
        if (!resetn_in)
        begin
            first_linreg_on_out <= 1'b0;
            first_linreg_voltage_code_out <= 4'h0;
            first_linreg_discharge_sel_out <= 2'h0;
        end
        else if (clk_en_in)
        begin
            first_linreg_on_out <= linreg[`PGL_B_ENABLE]
                & (linreg[`PGL_B_SDWN_CFG] | esd_state == pgl_pkg::PGL_ST_RUN);
            first_linreg_voltage_code_out <= linreg[`PGL_VID_MSB:`PGL_VID_LSB];
            first_linreg_discharge_sel_out <= linreg[`PGL_DIS_MSB:`PGL_DIS_LSB];
        end
    end

    a_pg3_mask_all: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && rail_mask[5:0] == 6'h3F && rail_mask[7] && pin_mask[7:3] == 5'h1F
         && pin_mask[0] && ctl_mask[1:0] == 2'h3) |=> pgood_output_three_out) // [R16]
        else $error("out3 low with all sources masked");
    a_pg3_rail_bad: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !rail_mask[0] && !pg_sync[0]) |=> !pgood_output_three_out) // [R2]
        else $error("out3 high with included rail bad");
    a_pg3_ldo2_bad: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !rail_mask[7] && !pg_sync[7]) |=> !pgood_output_three_out) // [R1]
        else $error("out3 high with linreg two bad");
    a_pg3_term_bad: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !pin_mask[3] && !pg_sync[9]) |=> !pgood_output_three_out) // [R4]
        else $error("out3 high with termination bad");
    a_pg3_ldo3_bad: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !pin_mask[0] && !pg_sync[8]) |=> !pgood_output_three_out) // [R5]
        else $error("out3 high with linreg three bad");
    a_pg3_in5_bad: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !pin_mask[7] && !ctl_sync[4]) |=> !pgood_output_three_out) // [R3]
        else $error("out3 high with input five low");
    a_out1_in3_low: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !ctl_mask[7] && !ctl_sync[2]) |=> !pgood_output_one_ctl_out) // [R6]
        else $error("out1 term high with input three low");
    a_out4_in6_low: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !ctl_mask[4] && !ctl_sync[5]) |=> !pgood_output_four_ctl_out) // [R7]
        else $error("out4 term high with input six low");
    a_out2_in3_low: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !ctl_mask[3] && !ctl_sync[2]) |=> !pgood_output_two_ctl_out) // [R8]
        else $error("out2 term high with input three low");
    a_out3_in6_low: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !ctl_mask[0] && !ctl_sync[5]) |=> !pgood_output_three_out) // [R9]
        else $error("out3 high with input six low");
    a_ldo_esd_off: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !linreg[`PGL_B_SDWN_CFG] && esd_state == pgl_pkg::PGL_ST_SHUT)
        |=> !first_linreg_on_out) // [R11]
        else $error("regulator on during emergency");
    a_ldo_en_only: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && linreg[`PGL_B_SDWN_CFG])
        |=> first_linreg_on_out == $past(linreg[`PGL_B_ENABLE])) // [R12]
        else $error("regulator ignores enable bit");
    a_ldo_fields: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && wr_in && addr_in == `PGL_OFF_LINREG) |=> ##1
        (first_linreg_voltage_code_out == $past(wdata_in[`PGL_VID_MSB:`PGL_VID_LSB], 2)
         && first_linreg_discharge_sel_out
            == $past(wdata_in[`PGL_DIS_MSB:`PGL_DIS_LSB], 2))) // [R10] [R13]
        else $error("regulator fields not following write");
    // no disable here: the check is about what reset itself leaves behind
    a_rst_defaults: assert property (@(posedge core_clk_in)
        !resetn_in |=> (rail_mask == OTP_RAIL_MASK && pin_mask == OTP_PIN_MASK
        && ctl_mask == OTP_CTL_MASK && linreg == OTP_LINREG)) // [R14]
        else $error("registers not at factory defaults after reset");
    a_rdata_idle: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && !rd_in) |=> rdata_out == 8'h00) // strobed register port: read data clears when rd_in is low
        else $error("read data not cleared without read strobe");
    a_esd_enter: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        (clk_en_in && esd_sync && esd_state == pgl_pkg::PGL_ST_RUN)
        |=> esd_state == pgl_pkg::PGL_ST_SHUT) // [R11]
        else $error("emergency hold not entered");
    c_esd_seen: cover property (@(posedge core_clk_in) esd_state == pgl_pkg::PGL_ST_SHUT);
    c_pg3_high: cover property (@(posedge core_clk_in) pgood_output_three_out);
    c_reg_read: cover property (@(posedge core_clk_in) rd_in && addr_in == `PGL_OFF_RAIL_MASK);
    c_ldo_held: cover property (@(posedge core_clk_in)
        linreg[`PGL_B_ENABLE] && !first_linreg_on_out);
    c_out1_low: cover property (@(posedge core_clk_in) !pgood_output_one_ctl_out);
endmodule : pgl_regbank
`default_nettype wire

// >>> bench/pgl_sys_model.sv
`timescale 1ns/1ns
`default_nettype none
module pgl_sys_model (
    input wire logic core_clk_in,
    input wire logic [14:0] bad_in,
    output logic [5:0] stepdown_pgood_out,
    output logic linreg_a_second_pgood_out,
    output logic linreg_a_third_pgood_out,
    output logic ddr_termination_pgood_out,
    output logic [5:0] control_input_out
);
    // good only in regulation
    // a set bit in bad_in means that source has left regulation or its pin is low
    always_ff @(posedge core_clk_in)
    begin
        stepdown_pgood_out <= ~bad_in[5:0];
        linreg_a_second_pgood_out <= ~bad_in[6];
        linreg_a_third_pgood_out <= ~bad_in[7];
        ddr_termination_pgood_out <= ~bad_in[8];
        control_input_out <= ~bad_in[14:9];
    end
endmodule : pgl_sys_model
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic esd = 1'b0;
    logic clk_en = 1'b1;
    logic [14:0] bad = 15'h0000;
    logic [7:0] rdata_out;
    logic [5:0] sd_pg;
    logic [5:0] ctl;
    logic l2_pg, l3_pg, term_pg, o1, o2, o3, o4, on;
    logic [3:0] vcode;
    logic [1:0] dis;
    int error_cnt = 0;
    int num_checks = 0;
    // mask place of each source: rails 1..6, linreg two, three, termination, inputs 1..6
    logic [7:0] ma [15] = '{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAB,
        8'hAB, 8'hAB, 8'hAB, 8'hAC, 8'hAB, 8'hAB, 8'hAC};
    int mb [15] = '{0, 1, 2, 3, 4, 5, 7, 0, 3, 4, 5, 1, 6, 7, 0};
    logic [7:0] ra [4] = '{8'hAA, 8'hAB, 8'hAC, 8'hAE};
    initial
    begin
        forever #50 core_clk_in = ~core_clk_in;
    end
    pgl_sys_model u_pgl_sys_model (.core_clk_in(core_clk_in), .bad_in(bad),
        .stepdown_pgood_out(sd_pg), .linreg_a_second_pgood_out(l2_pg),
        .linreg_a_third_pgood_out(l3_pg), .ddr_termination_pgood_out(term_pg),
        .control_input_out(ctl));
    pgl_regbank #(.ESD_CYCLES(8)) u_pgl_regbank (.core_clk_in(core_clk_in),
        .resetn_in(resetn_in), .clk_en_in(clk_en), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .stepdown_pgood_in(sd_pg),
        .linreg_a_second_pgood_in(l2_pg), .linreg_a_third_pgood_in(l3_pg),
        .ddr_termination_pgood_in(term_pg), .control_input_in(ctl),
        .emergency_shutdown_in(esd), .pgood_output_one_ctl_out(o1),
        .pgood_output_two_ctl_out(o2), .pgood_output_four_ctl_out(o4),
        .pgood_output_three_out(o3), .first_linreg_on_out(on),
        .first_linreg_voltage_code_out(vcode), .first_linreg_discharge_sel_out(dis));
    function automatic logic [7:0] base(input logic [7:0] a);
        // reserved bits kept set so any leak into the tree shows up
        return (a == 8'hAA) ? 8'h40 : ((a == 8'hAB) ? 8'h06 : 8'hFC);
    endfunction : base
    task automatic print_verdict;
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        @(negedge core_clk_in);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        @(negedge core_clk_in);
        chk(rdata_out, e);
    endtask : rd
    initial
    begin
        // generous bound, the sequence needs well under a thousand cycles
        #(5000 * 100);
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        int n;
        repeat (16) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        rd(8'hAA, 8'h40);
        rd(8'hAB, 8'h8E);
        rd(8'hAC, 8'hFF);
        rd(8'hAE, 8'h7D);
        // a write while the clock enable is low must not land
        @(posedge core_clk_in);
        clk_en <= 1'b0;
        wr(8'hAA, 8'h00);
        clk_en <= 1'b1;
        rd(8'hAA, 8'h40);
        wr(8'hAD, 8'hFF);
        rd(8'hAD, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            wr(ra[i], 8'h5A);
            rd(ra[i], 8'h5A);
            wr(ra[i], 8'hA5);
            rd(ra[i], 8'hA5);
        end
        for (int d = 0; d < 4; d++)
        begin
            wr(8'hAE, {2'(d), 1'b1, 4'(3 * d + 1), 1'b1});
            cyc(2);
            chk({6'h00, dis}, 8'(d));
            chk({4'h0, vcode}, 8'(3 * d + 1));
        end
        wr(8'hAA, 8'h40);
        wr(8'hAB, 8'h06);
        wr(8'hAC, 8'hFC);
        cyc(5);
        chk({7'h00, o3}, 8'h01);
        rd(8'hAF, 8'h01);
        for (int i = 0; i < 15; i++)
        begin
            @(posedge core_clk_in);
            bad <= 15'(1 << i);
            cyc(4);
            chk({7'h00, o3}, 8'h00);
            wr(ma[i], base(ma[i]) | 8'(1 << mb[i]));
            cyc(2);
            chk({7'h00, o3}, 8'h01);
            @(posedge core_clk_in);
            bad <= 15'h0000;
            wr(ma[i], base(ma[i]));
        end
        // input three fails first, then input six
        for (int j = 0; j < 2; j++)
        begin
            @(posedge core_clk_in);
            bad <= (j == 0) ? 15'h0800 : 15'h4000;
            wr(8'hAC, (j == 0) ? 8'h55 : 8'hAA);
            cyc(4);
            chk({4'h0, o1, o2, o4, o3}, 8'h00);
            wr(8'hAC, (j == 0) ? 8'hAA : 8'h55);
            cyc(2);
            chk({4'h0, o1, o2, o4, o3}, 8'h0F);
        end
        @(posedge core_clk_in);
        bad <= 15'h0000;
        wr(8'hAE, 8'h01);
        cyc(4);
        chk({7'h00, on}, 8'h01);
        @(posedge core_clk_in);
        esd <= 1'b1;
        cyc(4);
        chk({7'h00, on}, 8'h00);
        @(posedge core_clk_in);
        esd <= 1'b0;
        cyc(2);
        chk({7'h00, on}, 8'h00);
        n = 0;
        while (on !== 1'b1 && n < 40)
        begin
            cyc(1);
            n++;
        end
        chk({7'h00, on}, 8'h01);
        chk({7'h00, n > 2}, 8'h01);
        wr(8'hAE, 8'h21);
        cyc(3);
        @(posedge core_clk_in);
        esd <= 1'b1;
        cyc(5);
        chk({7'h00, on}, 8'h01);
        wr(8'hAE, 8'h20);
        cyc(3);
        chk({7'h00, on}, 8'h00);
        @(posedge core_clk_in);
        esd <= 1'b0;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
